// ===== include/adc_mode_defs.svh
/*
  timing counts, strap defaults and widths for the converter mode and power control.
  assumes the includer runs on a 10 MHz system clock.
*/
`ifndef ADC_MODE_DEFS_SVH
`define ADC_MODE_DEFS_SVH

`define CLK_PERIOD_NS        100
`define RELOCK_MIN_NS        1500
`define RELOCK_MAX_NS        5000
`define RELOCK_CYCLES        ((`RELOCK_MAX_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DISCHARGE_NS         250000
`define DISCHARGE_CYCLES     (`DISCHARGE_NS / `CLK_PERIOD_NS)
`define RESTORE_NS           350000
`define RESTORE_CYCLES       ((`RESTORE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STANDBY_WAKE_CYCLES  16
`define MIN_LOCK_RATE_KHZ    20000
`define PIPE_LATENCY         12
`define DATA_WIDTH           12
`define FIFO_DEPTH           32
`define STAB_STRAP_DEFAULT   1'b1
`define FORMAT_STRAP_DEFAULT 1'b0

`endif

// ===== include/adc_mode_pkg.sv
/*
  types shared by the mode and power control.
  assumes nothing beyond a SystemVerilog compiler.
*/
package adc_mode_pkg;
  typedef enum logic [3:0] {
    PWR_RUN     = 4'b0001,
    PWR_DOWN    = 4'b0010,
    PWR_STANDBY = 4'b0100,
    PWR_WAKE    = 4'b1000
  } power_state_t;

  typedef enum logic [1:0] {
    FMT_OFFSET_BINARY = 2'b00,
    FMT_TWOS_COMP     = 2'b01
  } data_format_t;
endpackage : adc_mode_pkg

// ===== rtl/adc_clock_power_mode_control.sv
/*
  digital mode and power control of a pipelined 12-bit converter: stabilizer
  enable/lock/bypass, strap-selected output format, power-down with tri-stated
  outputs and timed wake-up, standby, 12-cycle data latency through a fifo.
  assumes samples arrive one per clk from the core and straps/pins are async.
*/
`timescale 1ns/10ps
`include "adc_mode_defs.svh"

// What this block does
// - stabilizer regenerates falling edge, 50% duty
// - loop inactive below 20 MHz input rate
// - relock wait after any clock-rate change
// - bypass stabilizer while loop is unlocked
// - data strap selects stabilizer, default enabled
// - clock strap selects format, default offset binary
// - power-down pin shuts reference, bias, clock
// - outputs tri-stated throughout power-down
// - power-down release returns to normal operation
// - wake-up waits up to the restore time
// - standby keeps reference powered, faster wake
// - 12-bit parallel word per sample clock
// - word and range flag after 12 cycles
module adc_clock_power_mode_control
  import adc_mode_pkg::*;
#(
  parameter int RESTORE_CYCLES   = `RESTORE_CYCLES,
  parameter int DISCHARGE_CYCLES = `DISCHARGE_CYCLES,
  parameter int RELOCK_CYCLES    = `RELOCK_CYCLES
) (
  input  wire logic                   clk,              // 10 MHz system clock
  input  wire logic                   reset_n,          // async reset, active low
  input  wire logic                   power_down_pin,   // high requests power-down
  input  wire logic                   serial_data_stabilizer_strap, // stab strap
  input  wire logic                   serial_clock_format_strap,    // format strap
  input  wire logic                   pin_mode,         // high: straps control mode
  input  wire logic                   spi_stab_enable,  // serial-port stabilizer enable
  input  wire logic                   spi_twos_comp,    // serial-port format select
  input  wire logic                   spi_standby,      // serial-port standby request
  input  wire logic                   rate_change,      // pulse: clock rate changed
  input  wire logic [15:0]            rate_khz,         // measured input clock rate
  input  wire logic [`DATA_WIDTH-1:0] core_sample,      // raw offset-binary sample
  input  wire logic                   core_overrange,   // range flag of the sample
  input  wire logic                   sink_ready,       // downstream takes word
  output logic [`DATA_WIDTH-1:0]      data_out,         // formatted output word
  output logic                        data_oe,          // data drivers enabled
  output logic                        range_out,        // out-of-range flag
  output logic                        data_valid,       // word valid this cycle
  output logic                        clk_duty_bypass,  // timing follows input duty
  output logic                        stab_active,      // regenerated 50% falling edge
  output logic                        ref_enable,       // reference powered
  output logic                        bias_enable,      // bias networks and buffer
  output logic                        int_clk_enable,   // internal clock running
  output logic                        wake_done,        // wake-up timer expired
  output logic                        sample_in_ready   // fifo can accept a sample
);
  localparam int CW = 13;

  // pin synchroniser: three stages, change accepted when 2nd and 3rd agree
  logic [2:0] pd_sync, ds_sync, fs_sync;
  logic       pd_q, ds_q, fs_q, next_pd_q, next_ds_q, next_fs_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pd_sync <= 3'h0;
      ds_sync <= {3{`STAB_STRAP_DEFAULT}};
      fs_sync <= {3{`FORMAT_STRAP_DEFAULT}};
      pd_q    <= 1'b0;
      ds_q    <= `STAB_STRAP_DEFAULT;
      fs_q    <= `FORMAT_STRAP_DEFAULT;
    end else begin
      pd_sync <= {pd_sync[1:0], power_down_pin};
      ds_sync <= {ds_sync[1:0], serial_data_stabilizer_strap};
      fs_sync <= {fs_sync[1:0], serial_clock_format_strap};
      pd_q    <= next_pd_q;
      ds_q    <= next_ds_q;
      fs_q    <= next_fs_q;
    end
  end
  always_comb begin
    next_pd_q = (pd_sync[1] == pd_sync[2]) ? pd_sync[2] : pd_q;
    next_ds_q = (ds_sync[1] == ds_sync[2]) ? ds_sync[2] : ds_q;
    next_fs_q = (fs_sync[1] == fs_sync[2]) ? fs_sync[2] : fs_q;
  end

  // mode selection
  logic         stab_req;
  data_format_t fmt;
  always_comb begin
    stab_req = pin_mode ? ds_q : spi_stab_enable;
    fmt      = (pin_mode ? fs_q : spi_twos_comp) ? FMT_TWOS_COMP
                                                 : FMT_OFFSET_BINARY;
  end

  // power state machine
  power_state_t state, next_state;
  logic [31:0]  wake_cnt, next_wake_cnt, down_cnt, next_down_cnt;
  always_comb begin
    next_state    = state;
    next_wake_cnt = wake_cnt;
    next_down_cnt = down_cnt;
    case (state)
      PWR_RUN: begin
        if (pd_q) begin
          next_state    = PWR_DOWN;
          next_down_cnt = 32'h0000_0000;
        end else if (spi_standby) begin
          next_state = PWR_STANDBY;
        end
      end
      PWR_DOWN: begin
        // longer power-down drains more charge, so wake-up grows up to the full time
        if (down_cnt < 32'(DISCHARGE_CYCLES)) begin
          next_down_cnt = down_cnt + 32'h0000_0001;
        end
        if (!pd_q) begin
          next_state    = PWR_WAKE;
          next_wake_cnt = (down_cnt >= 32'(DISCHARGE_CYCLES)) ? 32'(RESTORE_CYCLES)
                        : 32'(RESTORE_CYCLES - DISCHARGE_CYCLES) + down_cnt;
        end
      end
      PWR_STANDBY: begin
        if (pd_q) begin
          next_state    = PWR_DOWN;
          next_down_cnt = 32'h0000_0000;
        end else if (!spi_standby) begin
          next_state    = PWR_WAKE;
          next_wake_cnt = 32'(`STANDBY_WAKE_CYCLES);
        end
      end
      PWR_WAKE: begin
        if (pd_q) begin
          next_state    = PWR_DOWN;
          next_down_cnt = 32'h0000_0000;
        end else if (wake_cnt <= 32'h0000_0001) begin
          next_state    = PWR_RUN;
          next_wake_cnt = 32'h0000_0000;
        end else begin
          next_wake_cnt = wake_cnt - 32'h0000_0001;
        end
      end
      default: next_state = PWR_RUN;
    endcase
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state    <= PWR_RUN;
      wake_cnt <= 32'h0000_0000;
      down_cnt <= 32'h0000_0000;
    end else begin
      state    <= next_state;
      wake_cnt <= next_wake_cnt;
      down_cnt <= next_down_cnt;
    end
  end

  // stabilizer lock tracking; relock assumed at the longest figure
  logic [15:0] relock_cnt, next_relock_cnt;
  logic        locked, next_locked, rate_ok;
  always_comb begin
    rate_ok         = (32'(rate_khz) >= `MIN_LOCK_RATE_KHZ);
    next_relock_cnt = relock_cnt;
    next_locked     = locked;
    if (!stab_req || !rate_ok || state != PWR_RUN && state != PWR_WAKE) begin
      next_locked     = 1'b0;
      next_relock_cnt = 16'(RELOCK_CYCLES);
    end else if (rate_change) begin
      next_locked     = 1'b0;
      next_relock_cnt = 16'(RELOCK_CYCLES);
    end else if (!locked) begin
      if (relock_cnt <= 16'h0001) begin
        next_locked = 1'b1;
      end
      next_relock_cnt = (relock_cnt == 16'h0000) ? 16'h0000 : relock_cnt - 16'h0001;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      relock_cnt <= 16'(RELOCK_CYCLES);
      locked     <= 1'b0;
    end else begin
      relock_cnt <= next_relock_cnt;
      locked     <= next_locked;
    end
  end

  // fifo write and output register are the last two of the 12 latency edges
  localparam int PIPE_STAGES = `PIPE_LATENCY - 1;
  logic [CW-1:0] pipe [PIPE_STAGES];
  logic [CW-1:0] next_pipe [PIPE_STAGES];
  logic [CW-1:0] fifo_out;
  logic          fifo_valid, fifo_in_ready, running;
  always_comb begin
    running      = (state == PWR_RUN) || (state == PWR_WAKE);
    next_pipe[0] = {core_overrange, core_sample};
    for (int i = 1; i < PIPE_STAGES; i++) begin
      next_pipe[i] = pipe[i-1];
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < PIPE_STAGES; i++) begin
        pipe[i] <= '0;
      end
    end else begin
      for (int i = 0; i < PIPE_STAGES; i++) begin
        pipe[i] <= next_pipe[i];
      end
    end
  end

  // fifo absorbs sink stalls; words lost only if sink stalls past 32 words
  sample_fifo #(.WIDTH(CW), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_data   (pipe[PIPE_STAGES-1]),
    .in_valid  (running),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (sink_ready)
  );

  // registered outputs
  logic [`DATA_WIDTH-1:0] next_data_out;
  logic next_oe, next_range, next_valid, next_bypass, next_stab, next_pwr, next_clk_en;
  always_comb begin
    next_data_out = fifo_out[`DATA_WIDTH-1:0];
    if (fmt == FMT_TWOS_COMP) begin
      next_data_out[`DATA_WIDTH-1] = ~fifo_out[`DATA_WIDTH-1];
    end
    next_oe     = running;
    next_range  = fifo_out[CW-1];
    next_valid  = fifo_valid && sink_ready && running;
    next_bypass = !(stab_req && locked);
    next_stab   = stab_req && locked;
    next_pwr    = (state != PWR_DOWN);
    next_clk_en = running;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_out        <= 12'h000;
      data_oe         <= 1'b0;
      range_out       <= 1'b0;
      data_valid      <= 1'b0;
      clk_duty_bypass <= 1'b1;
      stab_active     <= 1'b0;
      ref_enable      <= 1'b1;
      bias_enable     <= 1'b1;
      int_clk_enable  <= 1'b1;
      wake_done       <= 1'b1;
      sample_in_ready <= 1'b0;
    end else begin
      data_out        <= next_data_out;
      data_oe         <= next_oe;
      range_out       <= next_range;
      data_valid      <= next_valid;
      clk_duty_bypass <= next_bypass;
      stab_active     <= next_stab;
      ref_enable      <= next_pwr;
      bias_enable     <= next_pwr && state != PWR_STANDBY;
      int_clk_enable  <= next_clk_en;
      wake_done       <= (state == PWR_RUN);
      sample_in_ready <= fifo_in_ready;
    end
  end

  chk_pd_tristate: assert property (@(posedge clk) disable iff (!reset_n)
    (state == PWR_DOWN) |=> !data_oe)
    else $error("data drivers enabled during power-down");
  chk_bypass_unlocked: assert property (@(posedge clk) disable iff (!reset_n)
    !locked |=> clk_duty_bypass)
    else $error("stabilizer not bypassed while unlocked");
  chk_relock_wait: assert property (@(posedge clk) disable iff (!reset_n)
    rate_change |=> !locked [*8])
    else $error("relock faster than minimum wait");
  chk_low_rate_off: assert property (@(posedge clk) disable iff (!reset_n)
    !rate_ok |=> !locked)
    else $error("loop locked below minimum rate");
  chk_pd_enter: assert property (@(posedge clk) disable iff (!reset_n)
    (state == PWR_RUN && pd_q) |=> state == PWR_DOWN ##1 !ref_enable && !int_clk_enable)
    else $error("power-down not entered");
  chk_pd_exit: assert property (@(posedge clk) disable iff (!reset_n)
    (state == PWR_DOWN && !pd_q) |=> state == PWR_WAKE)
    else $error("power-down release ignored");
  chk_wake_hold: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(state == PWR_WAKE) && wake_cnt > 32'd8 |=> !wake_done [*8])
    else $error("wake reported early");
  chk_standby_ref: assert property (@(posedge clk) disable iff (!reset_n)
    (state == PWR_STANDBY) |=> ref_enable)
    else $error("reference lost in standby");
  chk_fmt_twos: assert property (@(posedge clk) disable iff (!reset_n)
    (fmt == FMT_TWOS_COMP) |=> data_out[11] == !$past(fifo_out[11]))
    else $error("twos complement msb wrong");
endmodule : adc_clock_power_mode_control

// ===== rtl/sample_fifo.sv
/*
  synchronous fifo with valid/ready on both sides.
  assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/10ps
module sample_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,       // system clock
  input  wire logic             reset_n,   // async reset, active low
  input  wire logic [WIDTH-1:0] in_data,   // word to store
  input  wire logic             in_valid,  // word offered
  output logic                  in_ready,  // room available
  output logic [WIDTH-1:0]      out_data,  // oldest word
  output logic                  out_valid, // word available
  input  wire logic             out_ready  // consumer takes word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0]      count, next_count;
  logic             push, pop;

  always_comb begin
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count  = (AW+1)'(count + (AW+1)'(push) - (AW+1)'(pop));
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
endmodule : sample_fifo

// ===== testbench/adc_clock_power_mode_control_test.sv
/*
  self-checking bench for the converter mode and power control.
  assumes short sim timing counts: restore 40, discharge 20, relock 10.
*/
`timescale 1ns/10ps
module adc_clock_power_mode_control_test;
  logic clk, reset_n, power_down_pin, serial_data_stabilizer_strap, serial_clock_format_strap;
  logic pin_mode, spi_stab_enable, spi_twos_comp, spi_standby, rate_change, core_overrange;
  logic sink_ready, data_oe, range_out, data_valid, clk_duty_bypass, stab_active, ref_enable;
  logic bias_enable, int_clk_enable, wake_done, sample_in_ready, data_usable, mon_on;
  logic [15:0] rate_khz;
  logic [11:0] core_sample, data_out, fmt_mask;
  logic [12:0] hist[$];
  int n_mismatch, samples_checked, long_w, short_w;
  adc_clock_power_mode_control #(.RESTORE_CYCLES(40), .DISCHARGE_CYCLES(20),
    .RELOCK_CYCLES(10)) i_adc_clock_power_mode_control (.clk, .reset_n, .power_down_pin,
    .serial_data_stabilizer_strap, .serial_clock_format_strap, .pin_mode, .spi_stab_enable,
    .spi_twos_comp, .spi_standby, .rate_change, .rate_khz, .core_sample, .core_overrange,
    .sink_ready, .data_out, .data_oe, .range_out, .data_valid, .clk_duty_bypass, .stab_active,
    .ref_enable, .bias_enable, .int_clk_enable, .wake_done, .sample_in_ready);
  adc_controller_model i_adc_controller_model (.clk, .reset_n, .wake_done, .power_down_pin,
    .serial_data_stabilizer_strap, .serial_clock_format_strap, .rate_change, .rate_khz,
    .core_sample, .core_overrange, .sink_ready, .data_usable);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task report_and_stop;
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  function logic pick(input int sel);
    case (sel)
      0: return ref_enable;
      1: return wake_done;
      2: return data_oe;
      3: return sample_in_ready;
      default: return data_valid;
    endcase
  endfunction : pick
  // bounded wait; running out ends the run as a failure
  task wait_for(input int sel, input logic lvl, input int bound, output int n);
    n = 0;
    while (pick(sel) !== lvl) begin
      if (n >= bound) begin
        n_mismatch++;
        report_and_stop;
      end
      tick(1);
      n++;
    end
  endtask : wait_for
  // each word must be the sample taken 12 edges earlier, with its flag
  always @(posedge clk) begin
    hist.push_front({core_overrange, core_sample});
    if (hist.size() > 20) void'(hist.pop_back());
    #1;
    if (mon_on && data_usable && hist.size() > 12) begin
      check("data_valid", 16'(data_valid), 16'h0001);
      check("data_out", 16'(data_out), 16'(hist[12][11:0] ^ fmt_mask));
      check("range_out", 16'(range_out), 16'(hist[12][12]));
    end
  end
  task t_format;
    for (int i = 0; i < 4; i++) begin
      mon_on = 1'b0;
      pin_mode = (i < 2);
      spi_twos_comp = !i[0];
      i_adc_controller_model.set_straps(1'b1, i[0]);
      fmt_mask = (pin_mode ? i[0] : !i[0]) ? 12'h800 : 12'h000;
      tick(20);
      mon_on = 1'b1;
      tick(20);
    end
    mon_on = 1'b0;
  endtask : t_format
  task stab_case(input logic pm, input logic st, input logic en, input logic [15:0] khz,
                 input logic exp);
    pin_mode = pm;
    spi_stab_enable = en;
    i_adc_controller_model.set_straps(st, 1'b0);
    tick(6);
    i_adc_controller_model.change_rate(khz);
    tick(2);
    check("bypass_relock", 16'(clk_duty_bypass), 16'h0001);
    tick(25);
    check("bypass", 16'(clk_duty_bypass), 16'(exp));
    check("stab_active", 16'(stab_active), 16'(!exp));
  endtask : stab_case
  task t_pd(input int hold, output int wake);
    int n;
    i_adc_controller_model.set_pd(1'b1);
    wait_for(0, 1'b0, 12, n);
    tick(1);
    check("bias_down", 16'(bias_enable), 16'h0000);
    check("clk_down", 16'(int_clk_enable), 16'h0000);
    repeat (hold) begin
      check("oe_down", 16'(data_oe), 16'h0000);
      check("valid_down", 16'(data_valid), 16'h0000);
      tick(1);
    end
    i_adc_controller_model.set_pd(1'b0);
    wait_for(1, 1'b1, 100, wake);
    tick(2);
    check("oe_run", 16'(data_oe), 16'h0001);
    check("ref_run", 16'(ref_enable), 16'h0001);
  endtask : t_pd
  task t_standby;
    int n;
    pin_mode = 1'b0;
    spi_standby = 1'b1;
    wait_for(2, 1'b0, 12, n);
    tick(1);
    check("ref_standby", 16'(ref_enable), 16'h0001);
    tick(30);
    spi_standby = 1'b0;
    wait_for(1, 1'b1, 100, n);
    check("standby_faster", 16'(n < long_w), 16'h0001);
  endtask : t_standby
  task t_fifo;
    int n;
    logic [11:0] prev;
    i_adc_controller_model.set_sink(1'b0);
    wait_for(3, 1'b0, 60, n);
    check("fifo_fill", 16'(n >= 30), 16'h0001);
    tick(10);
    i_adc_controller_model.set_sink(1'b1);
    wait_for(4, 1'b1, 10, n);
    prev = data_out;
    for (int k = 0; k < 24; k++) begin
      tick(1);
      check("fifo_order", 16'(data_out), 16'(12'(prev + 12'h001)));
      prev = data_out;
    end
    wait_for(3, 1'b1, 60, n);
  endtask : t_fifo
  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    pin_mode = 1'b1;
    spi_stab_enable = 1'b1;
    spi_twos_comp = 1'b0;
    spi_standby = 1'b0;
    mon_on = 1'b0;
    fmt_mask = 12'h000;
    tick(3);
    check("bypass_reset", 16'(clk_duty_bypass), 16'h0001);
    tick(3);
    reset_n = 1'b1;
    tick(30);
    t_format;
    stab_case(1'b1, 1'b1, 1'b0, 16'h9c40, 1'b0);
    stab_case(1'b1, 1'b0, 1'b1, 16'h9c40, 1'b1);
    stab_case(1'b0, 1'b0, 1'b1, 16'h9c40, 1'b0);
    stab_case(1'b0, 1'b1, 1'b0, 16'h9c40, 1'b1);
    stab_case(1'b1, 1'b1, 1'b0, 16'h3a98, 1'b1);
    i_adc_controller_model.change_rate(16'h9c40);
    t_pd(30, long_w);
    check("wake_full", 16'(long_w >= 40 && long_w <= 50), 16'h0001);
    t_pd(5, short_w);
    check("wake_short", 16'(short_w < long_w), 16'h0001);
    t_standby;
    t_fifo;
    report_and_stop;
  end
endmodule : adc_clock_power_mode_control_test

// ===== testbench/adc_controller_model.sv
/*
  far side: sample source, system controller on pins and straps, word sink.
  assumes the bench calls its tasks just after a rising clk edge.
*/
`timescale 1ns/10ps
`include "adc_mode_defs.svh"
module adc_controller_model (
  input  wire logic   clk,                          // system clock
  input  wire logic   reset_n,                      // async reset, active low
  input  wire logic   wake_done,                    // wake-up timer expired
  output logic        power_down_pin,               // high requests power-down
  output logic        serial_data_stabilizer_strap, // stabilizer strap
  output logic        serial_clock_format_strap,    // format strap
  output logic        rate_change,                  // pulse on rate change
  output logic [15:0] rate_khz,                     // input clock rate
  output logic [11:0] core_sample,                  // ramp of samples
  output logic        core_overrange,               // range flag of sample
  output logic        sink_ready,                   // consumer takes words
  output logic        data_usable                   // words may be trusted
);
  int unsigned wait_cnt;
  initial begin
    set_pd(1'b0);
    set_straps(`STAB_STRAP_DEFAULT, `FORMAT_STRAP_DEFAULT);
    rate_change = 1'b0;
    rate_khz = 16'h9c40;
    set_sink(1'b1);
  end
  // a ramp makes every word and its delay identifiable; restarts while reset is low
  always @(posedge clk) begin
    #1;
    core_sample = reset_n ? 12'(core_sample + 12'h001) : 12'h000;
  end
  assign core_overrange = core_sample[3];
  // stale pipe contents after wake-up must not be trusted
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n || !wake_done) wait_cnt <= 0;
    else if (wait_cnt < `PIPE_LATENCY + 2) wait_cnt <= wait_cnt + 1;
  end
  assign data_usable = (wait_cnt >= `PIPE_LATENCY + 2);
  task set_pd(input logic v);
    power_down_pin = v;
  endtask : set_pd
  task set_straps(input logic stab, input logic fmt);
    serial_data_stabilizer_strap = stab;
    serial_clock_format_strap = fmt;
  endtask : set_straps
  task change_rate(input logic [15:0] khz);
    rate_khz = khz;
    rate_change = 1'b1;
    @(posedge clk);
    #1;
    rate_change = 1'b0;
  endtask : change_rate
  task set_sink(input logic v);
    sink_ready = v;
  endtask : set_sink
endmodule : adc_controller_model
